// ---- rtl/ess_pkg.sv ----
// Constants for the enable, start-up and mode sequencer.
// Assumes a 100 MHz core clock and a 32-bit byte-addressed slave.
package ess_pkg;
  localparam int CLK_MHZ = 100;
  // Register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_RAMP = 5'h04;
  localparam logic [4:0] OFS_STACK = 5'h08;
  localparam logic [4:0] OFS_SETPT = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  // Field positions
  localparam int FORCED_PULSE_WIDTH_OPERATION_BIT = 0;
  localparam int RNG_LSB = 1;
  localparam int DUR_LSB = 0;
  localparam int SOLO_BIT = 0;
  // Reset and default values
  localparam logic FORCED_PULSE_WIDTH_OPERATION_RST = 1'b0;
  localparam logic [1:0] RNG_RST = 2'h2;
  localparam logic [1:0] DUR_RST = 2'h1;
  localparam logic SOLO_RST = 1'b0;
  localparam logic [7:0] SETPT_RST = 8'h46;
  // Default setpoint per voltage strap code
  localparam logic [7:0] VOLTAGE_STRAP_PIN_SET [4] = '{8'h46, 8'h5a, 8'h78, 8'h5f};
  // Switching period in core cycles per frequency strap code
  localparam logic [7:0] FREQUENCY_STRAP_PIN_DIV [4] = '{8'h42, 8'h2c, 8'h28, 8'h21};
  // Times
  localparam int RAMP_US [4] = '{500, 1000, 2000, 4000};
  localparam int INIT_US = 20;
  localparam int START_US = 10;
  localparam int SYNC_WIN_NS = 2000;
  localparam int MIN_ON_NS = 50;
  localparam int SYNC_WIN_CYC = SYNC_WIN_NS * CLK_MHZ / 1000;
  localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_CYC0 = RAMP_US[0] * CLK_MHZ;
  localparam int RAMP_CYC1 = RAMP_US[1] * CLK_MHZ;
  localparam int RAMP_CYC2 = RAMP_US[2] * CLK_MHZ;
  localparam int RAMP_CYC3 = RAMP_US[3] * CLK_MHZ;
  localparam int INIT_CYC = INIT_US * CLK_MHZ;
  localparam int START_CYC = START_US * CLK_MHZ;
  // Load classes from the current sense
  localparam logic [1:0] LOAD_VLOW = 2'h0;
  localparam logic [1:0] LOAD_LOW = 2'h1;
  typedef enum logic [2:0] {
    ST_OFF, ST_INIT, ST_IDLE, ST_DELAY, ST_RAMP, ST_RUN
  } ess_state_e;
endpackage

// ---- rtl/ess_seq.sv ----
// Enable line, start-up, soft-start and mode sequencer with registers.
// Assumes pins arrive asynchronous and the bus master obeys Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// - Power save only if pin low, bit clear
// - Forced PWM runs continuous current except during the ramp
// - Power save picks CCM, DCM, PFM by load
// - PFM pulses align to switching clock
// - Minimum on time 50 ns, lower frequency
// - On supply, hold enable, sample straps, defaults
// - After init, open bus, release enable
// - Faults pull enable low unless standalone
// - Shared enable holds and stops whole stack
// - Standalone skips fault pulldown, keeps init pulldown
// - Idle line is plain input, high enables
// - Bus works regardless of enable state
// - Enable low means shutdown, stage off
// - Enable toggling never reloads registers
// - Enable high starts ramp after delay
// - Ramp field picks 500us to 4ms
// - Ramp-time writes defer until ramp ends
// - Ramp to captured setpoint, then new
// - Soft-start ramp always in discontinuous mode
// - Enable pin also outputs stack hold
module ess_seq
  import ess_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int START_CYCLES = START_CYC,
  parameter int RAMP_CYCLES0 = RAMP_CYC0,
  parameter int RAMP_CYCLES1 = RAMP_CYC1,
  parameter int RAMP_CYCLES2 = RAMP_CYC2,
  parameter int RAMP_CYCLES3 = RAMP_CYC3
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic supply_ok, // Supply above lockout
  input wire logic en_i, // Enable pin level
  output logic en_o, // Enable pin drive value
  output logic en_oe, // Enable pulldown active
  input wire logic mode_pin, // Operating-select pin
  input wire logic [1:0] voltage_strap_pin, // Setpoint strap code
  input wire logic [1:0] frequency_strap_pin, // Frequency strap code
  input wire logic stack_sync_out_pin, // Sync-out strap
  input wire logic fault_tsd, // Thermal shutdown
  input wire logic fault_ovlo, // Overvoltage lockout
  input wire logic [1:0] load_class, // Load level class
  input wire logic pfm_demand, // Skip-mode energy request
  input wire logic [7:0] on_req, // Requested on time
  output logic ref_en, // Reference enable
  output logic stage_on, // Power stage active
  output logic ramp_active, // Soft start running
  output logic op_ccm, // Continuous-current PWM
  output logic op_dcm, // Discontinuous PWM
  output logic op_pfm, // Pulse skipping
  output logic [7:0] target, // Effective setpoint
  output logic [1:0] target_range, // Effective range
  output logic sw_tick, // Switching clock tick
  output logic hs_on // High-side gate
);
  localparam int CW = 19;
  initial begin
    if (RAMP_CYCLES3 >= (1 << CW) || INIT_CYCLES < 1 ||
        START_CYCLES < 1 || RAMP_CYCLES0 < 1 ||
        INIT_CYCLES >= (1 << CW) || START_CYCLES >= (1 << CW)) begin
      $error("ess_seq: cycle counts out of range");
    end
  end

  function automatic logic [CW-1:0] ramp_len(input logic [1:0] c);
    unique case (c)
      2'h0: ramp_len = CW'(RAMP_CYCLES0);
      2'h1: ramp_len = CW'(RAMP_CYCLES1);
      2'h2: ramp_len = CW'(RAMP_CYCLES2);
      2'h3: ramp_len = CW'(RAMP_CYCLES3);
    endcase
  endfunction

  // Pin synchronisers
  logic [8:0] pin_s;
  ess_sync2 #(.WIDTH(9)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({supply_ok, en_i, mode_pin, fault_tsd, fault_ovlo, load_class,
        pfm_demand, stack_sync_out_pin}),
    .q(pin_s)
  );
  logic [3:0] strap_s;
  ess_sync2 #(.WIDTH(4)) u_strap (
    .clk(clk),
    .rst(rst),
    .d({voltage_strap_pin, frequency_strap_pin}),
    .q(strap_s)
  );
  logic sup_s, en_s, mode_s, fault_s, dem_s, sout_s;
  logic [1:0] load_s;
  assign sup_s = pin_s[8];
  assign en_s = pin_s[7];
  assign mode_s = pin_s[6];
  assign fault_s = pin_s[5] | pin_s[4];
  assign load_s = pin_s[3:2];
  assign dem_s = pin_s[1];
  assign sout_s = pin_s[0];

  // Sequencer state
  ess_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] set_q, set_d, eset_q, eset_d;
  logic [1:0] rng_q, rng_d, arng_q, arng_d, erng_q, erng_d;
  logic [1:0] dur_q, dur_d, edur_q, edur_d;
  logic forced_pulse_width_operation_q, forced_pulse_width_operation_d, solo_q, solo_d;
  logic [1:0] frequency_strap_pin_q, frequency_strap_pin_d;
  logic sout_q, sout_d, ready, power_save_operation;
  // Bus state
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic req, wr_go, lane0;
  assign ready = !(st_q inside {ST_OFF, ST_INIT});
  assign req = avs_read | avs_write;
  assign wr_go = avs_write && ack_q;
  assign lane0 = avs_byteenable[0];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CW'(1);
    unique case (st_q)
      ST_OFF: begin
        cnt_d = '0;
        if (sup_s) begin
          st_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (cnt_q == CW'(INIT_CYCLES - 1)) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        cnt_d = '0;
        if (en_s) begin
          st_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!en_s) begin
          st_d = ST_IDLE;
        end else if (cnt_q == CW'(START_CYCLES - 1)) begin
          st_d = ST_RAMP;
          cnt_d = '0;
        end
      end
      ST_RAMP: begin
        if (!en_s) begin
          st_d = ST_IDLE;
        end else if (cnt_q == ramp_len(edur_q) - CW'(1)) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_d = '0;
        if (!en_s) begin
          st_d = ST_IDLE;
        end
      end
    endcase
    if (!sup_s) begin
      st_d = ST_OFF;
    end
  end

  // Register file and effective values
  always_comb begin
    set_d = set_q;
    rng_d = rng_q;
    arng_d = arng_q;
    dur_d = dur_q;
    forced_pulse_width_operation_d = forced_pulse_width_operation_q;
    solo_d = solo_q;
    frequency_strap_pin_d = frequency_strap_pin_q;
    sout_d = sout_q;
    // Defaults only at end of init, never on enable toggles
    if (st_q == ST_INIT && st_d == ST_IDLE) begin
      set_d = VOLTAGE_STRAP_PIN_SET[strap_s[3:2]];
      frequency_strap_pin_d = strap_s[1:0];
      sout_d = sout_s;
      rng_d = RNG_RST;
      arng_d = RNG_RST;
      dur_d = DUR_RST;
      forced_pulse_width_operation_d = FORCED_PULSE_WIDTH_OPERATION_RST;
      solo_d = SOLO_RST;
    end else if (wr_go && lane0 && ready) begin
      unique case (avs_address)
        OFS_MODE: begin
          forced_pulse_width_operation_d = avs_writedata[FORCED_PULSE_WIDTH_OPERATION_BIT];
          rng_d = avs_writedata[RNG_LSB +: 2];
        end
        OFS_RAMP: dur_d = avs_writedata[DUR_LSB +: 2];
        OFS_STACK: solo_d = avs_writedata[SOLO_BIT];
        OFS_SETPT: begin
          set_d = avs_writedata[7:0];
          arng_d = rng_q;
        end
        default: ;
      endcase
    end
    // Live values are frozen for the whole ramp
    eset_d = set_q;
    erng_d = arng_q;
    edur_d = dur_q;
    if (st_q == ST_RAMP || st_d == ST_RAMP) begin
      eset_d = eset_q;
      erng_d = erng_q;
      edur_d = edur_q;
    end
    if (st_q == ST_DELAY && st_d == ST_RAMP) begin
      eset_d = set_q;
      erng_d = arng_q;
      edur_d = dur_q;
    end
  end

  // Avalon slave: one stall cycle, read data from a register
  always_comb begin
    ack_d = req && !ack_q && ready;
    rd_d = rd_q;
    if (avs_read && !ack_q) begin
      unique case (avs_address)
        OFS_MODE: rd_d = {29'h0, rng_q, forced_pulse_width_operation_q};
        OFS_RAMP: rd_d = {30'h0, dur_q};
        OFS_STACK: rd_d = {31'h0, solo_q};
        OFS_SETPT: rd_d = {24'h0, set_q};
        OFS_STAT: rd_d = {8'h0, eset_q, 5'h0, sout_q, frequency_strap_pin_q,
                          1'h0, erng_q, power_save_operation, fault_s, ramp_active,
                          en_s, ready};
        default: rd_d = 32'h0;
      endcase
    end
  end
  assign avs_waitrequest = !ack_q;
  assign avs_readdata = rd_q;

  // Sync clock on the select pin counts as a high level
  logic mprev_q, mprev_d, sync_seen;
  logic [11:0] scnt_q, scnt_d;
  always_comb begin
    mprev_d = mode_s;
    scnt_d = scnt_q;
    if (mode_s != mprev_q) begin
      scnt_d = 12'h000;
    end else if (scnt_q != 12'(SYNC_WIN_CYC)) begin
      scnt_d = scnt_q + 12'h001;
    end
  end
  assign sync_seen = scnt_q != 12'(SYNC_WIN_CYC);
  assign power_save_operation = !mode_s && !forced_pulse_width_operation_q && !sync_seen;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_OFF;
      cnt_q <= '0;
      set_q <= SETPT_RST;
      eset_q <= SETPT_RST;
      rng_q <= RNG_RST;
      arng_q <= RNG_RST;
      erng_q <= RNG_RST;
      dur_q <= DUR_RST;
      edur_q <= DUR_RST;
      forced_pulse_width_operation_q <= FORCED_PULSE_WIDTH_OPERATION_RST;
      solo_q <= SOLO_RST;
      frequency_strap_pin_q <= 2'h0;
      sout_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 32'h0;
      mprev_q <= 1'b0;
      scnt_q <= 12'h000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      set_q <= set_d;
      eset_q <= eset_d;
      rng_q <= rng_d;
      arng_q <= arng_d;
      erng_q <= erng_d;
      dur_q <= dur_d;
      edur_q <= edur_d;
      forced_pulse_width_operation_q <= forced_pulse_width_operation_d;
      solo_q <= solo_d;
      frequency_strap_pin_q <= frequency_strap_pin_d;
      sout_q <= sout_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      mprev_q <= mprev_d;
      scnt_q <= scnt_d;
    end
  end

  // Enable line: open-drain pulldown carries the stack hold
  assign en_oe = !ready || (fault_s && !solo_q);
  assign en_o = 1'b0;
  assign ref_en = st_q != ST_OFF;
  assign ramp_active = st_q == ST_RAMP;
  assign stage_on = (st_q inside {ST_RAMP, ST_RUN}) && !fault_s;
  assign target = eset_q;
  assign target_range = erng_q;

  // Conduction mode
  always_comb begin
    op_ccm = 1'b0;
    op_dcm = 1'b0;
    op_pfm = 1'b0;
    if (!stage_on) begin
      op_ccm = 1'b0;
    end else if (ramp_active) begin
      op_dcm = 1'b1;
    end else if (!power_save_operation) begin
      op_ccm = 1'b1;
    end else if (load_s == LOAD_VLOW) begin
      op_pfm = 1'b1;
    end else if (load_s == LOAD_LOW) begin
      op_dcm = 1'b1;
    end else begin
      op_ccm = 1'b1;
    end
  end

  ess_sw_pulse u_pulse (
    .clk(clk),
    .rst(rst),
    .run(stage_on),
    .period(FREQUENCY_STRAP_PIN_DIV[frequency_strap_pin_q]),
    .skip_ok(op_pfm),
    .demand(dem_s),
    .on_req(on_req),
    .sw_tick(sw_tick),
    .hs_on(hs_on)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_psm_sel;
    stage_on && !ramp_active && (forced_pulse_width_operation_q || mode_s) |-> !op_pfm && op_ccm;
  endproperty
  a_psm_sel: assert property (p_psm_sel)
    else $error("forced PWM not selected");
  property p_ramp_dcm;
    ramp_active && stage_on |-> op_dcm && !op_ccm && !op_pfm;
  endproperty
  a_ramp_dcm: assert property (p_ramp_dcm)
    else $error("ramp not in DCM");
  property p_init_hold;
    st_q == ST_INIT |-> en_oe && avs_waitrequest;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("enable not held during init");
  property p_release;
    st_q == ST_INIT && st_d == ST_IDLE ##1 !fault_s |-> !en_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("enable not released");
  property p_fault_pull;
    fault_s && !solo_q |-> en_oe && !stage_on;
  endproperty
  a_fault_pull: assert property (p_fault_pull)
    else $error("fault did not pull enable");
  property p_solo;
    ready && solo_q |-> !en_oe;
  endproperty
  a_solo: assert property (p_solo)
    else $error("standalone pulldown active");
  property p_off;
    ready && !en_s |=> !stage_on;
  endproperty
  a_off: assert property (p_off)
    else $error("stage on with enable low");
  property p_keep;
    st_q inside {ST_IDLE, ST_RUN} && !wr_go && sup_s |=> $stable(set_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("setpoint changed without write");
  property p_freeze;
    ramp_active && $past(ramp_active) |-> $stable(eset_q) && $stable(edur_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("value changed during ramp");
  property p_bus;
    req && ready && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer late");
  property p_minon;
    $rose(hs_on) |-> (hs_on || !stage_on) [*5];
  endproperty
  a_minon: assert property (p_minon)
    else $error("on time below minimum");
  property p_pfm_tick;
    op_pfm && $rose(hs_on) |-> $past(sw_tick);
  endproperty
  a_pfm_tick: assert property (p_pfm_tick)
    else $error("PFM pulse off clock");
  c_ramp_done: cover property (st_q == ST_RAMP ##1 st_q == ST_RUN);
  c_fault: cover property (fault_s && en_oe && ready);
  c_pfm: cover property (op_pfm && hs_on);
  c_rd: cover property (avs_read && !avs_waitrequest);
endmodule

// ---- rtl/ess_sw_pulse.sv ----
// High-side pulse generator locked to the internal switching clock.
// Assumes on_req comes from loop logic on the same clock.
`timescale 1ns/1ps
module ess_sw_pulse
  import ess_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic run, // Power stage allowed
  input wire logic [7:0] period, // Switching period, cycles
  input wire logic skip_ok, // Pulse skipping allowed
  input wire logic demand, // Loop asks for energy
  input wire logic [7:0] on_req, // Requested on time, cycles
  output logic sw_tick, // Switching clock tick
  output logic hs_on // High-side gate
);
  logic [7:0] ph_q, ph_d, on_q, on_d;
  logic alt_q, alt_d, short_req, fire;
  always_comb begin
    ph_d = (ph_q >= period - 8'h01) ? 8'h00 : ph_q + 8'h01;
    sw_tick = (ph_q == 8'h00);
    short_req = on_req < 8'(MIN_ON_CYC);
    alt_d = alt_q;
    // Pulses start only on a switching tick
    fire = run && sw_tick && (!skip_ok || demand) && (!short_req || alt_q);
    if (run && sw_tick && short_req) begin
      alt_d = !alt_q;
    end
    on_d = (on_q != 8'h00) ? on_q - 8'h01 : 8'h00;
    if (!run) begin
      on_d = 8'h00;
    end else if (fire) begin
      on_d = short_req ? 8'(MIN_ON_CYC) : on_req;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 8'h00;
      on_q <= 8'h00;
      alt_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      on_q <= on_d;
      alt_q <= alt_d;
    end
  end
  assign hs_on = on_q != 8'h00;
endmodule

// ---- rtl/ess_sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels.
// Only the second stage may be read by other logic.
`timescale 1ns/1ps
module ess_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic [WIDTH-1:0] d, // Async level
  output logic [WIDTH-1:0] q // Synchronised level
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- test/ess_peer.sv ----
// Partner model: one stacked converter plus the external enable driver.
// Assumes a single open-drain enable wire pulled up to the driver level.
`timescale 1ns/1ps
module ess_peer #(
  parameter int INIT_CYCLES = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic ext_en, // External enable driver level
  input wire logic fault, // Peer fault, set by bench
  input wire logic dut_oe, // Device pulldown active
  output logic en_wire // Resolved enable wire
);
  localparam logic PEER_SOLO = 1'b0;
  localparam logic PEER_FORCED_PULSE_WIDTH_OPERATION = 1'b1;
  int cnt_q;
  logic hold;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
    end else if (cnt_q < INIT_CYCLES) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // Peer holds the line through its own init and on its faults
  assign hold = (cnt_q < INIT_CYCLES) || (fault && !PEER_SOLO);
  // Any pulldown wins over the pull-up
  assign en_wire = ext_en && !dut_oe && !hold && PEER_FORCED_PULSE_WIDTH_OPERATION;
endmodule

// ---- test/ess_seq_tb.sv ----
// Bench for the sequencer: bus tasks, enable link, mode and ramp checks.
// Assumes short init, start and ramp counts set through parameters.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module ess_seq_tb;
  import ess_pkg::*;
  localparam int START_N = 4;
  localparam int RC [4] = '{20, 40, 80, 160};
  logic clk = 1'b0, rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, en_wire, en_o, en_oe, ref_en, stage_on;
  logic supply_ok = 1'b1, mode_pin = 1'b0, sync_strap = 1'b0;
  logic fault_tsd = 1'b0, fault_ovlo = 1'b0, ext_en = 1'b0;
  logic peer_fault = 1'b0, pfm_demand = 1'b1;
  logic [1:0] vstrap = 2'h2, fstrap = 2'h1, load_class = 2'h0;
  logic [7:0] on_req = 8'h01, target;
  logic [1:0] target_range;
  logic ramp_active, op_ccm, op_dcm, op_pfm, sw_tick, hs_on;
  int n_errors = 0, cmp_count = 0, t, l, hl = 0, rl = 0;
  logic mp [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic fb [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [1:0] ld [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic [2:0] ex [5] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h4};
  always #5 clk = ~clk;
  ess_seq #(.INIT_CYCLES(8), .START_CYCLES(START_N), .RAMP_CYCLES0(20),
    .RAMP_CYCLES1(40), .RAMP_CYCLES2(80), .RAMP_CYCLES3(160)) dut (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_ok(supply_ok), .en_i(en_wire), .en_o(en_o), .en_oe(en_oe),
    .mode_pin(mode_pin), .voltage_strap_pin(vstrap),
    .frequency_strap_pin(fstrap), .stack_sync_out_pin(sync_strap),
    .fault_tsd(fault_tsd), .fault_ovlo(fault_ovlo),
    .load_class(load_class), .pfm_demand(pfm_demand), .on_req(on_req),
    .ref_en(ref_en), .stage_on(stage_on), .ramp_active(ramp_active),
    .op_ccm(op_ccm), .op_dcm(op_dcm), .op_pfm(op_pfm), .target(target),
    .target_range(target_range), .sw_tick(sw_tick), .hs_on(hs_on));
  ess_peer #(.INIT_CYCLES(8)) peer (.clk(clk), .rst(rst), .ext_en(ext_en),
    .fault(peer_fault), .dut_oe(en_oe), .en_wire(en_wire));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic ramp_go();
    ext_en <= 1'b0;
    cyc(6);
    ext_en <= 1'b1;
    t = 0;
    while (ramp_active !== 1'b1 && t < 100) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic ramp_len();
    l = 0;
    while (ramp_active === 1'b1 && l < 1000) begin
      @(posedge clk);
      l++;
    end
    l = rl;
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // High-side pulses never shorter than the minimum on time
  always @(posedge clk) begin
    if (hs_on === 1'b1) begin
      hl <= hl + 1;
    end else begin
      if (hl > 0 && stage_on === 1'b1) `CHK(hl >= MIN_ON_CYC, 1'b1)
      hl <= 0;
    end
  end
  // Full soft-start length, even when measured from mid-ramp
  always @(posedge clk) begin
    rl <= (ramp_active === 1'b1) ? rl + 1 : 0;
  end
  initial begin
    #200us;
    n_errors++;
    wrap_up();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(4);
    `CHK(en_oe, 1'b1)
    `CHK(ref_en, 1'b1)
    cyc(16);
    `CHK(en_oe, 1'b0)
    `CHK(en_o, 1'b0)
    `CHK(stage_on, 1'b0)
    rchk(OFS_MODE, 32'h4);
    rchk(OFS_RAMP, 32'h1);
    rchk(OFS_STACK, 32'h0);
    rchk(OFS_SETPT, 32'h78);
    `CHK(target, 8'h78)
    while (sw_tick !== 1'b1) @(posedge clk);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (sw_tick !== 1'b1);
    `CHK(t, FREQUENCY_STRAP_PIN_DIV[1])
    bus(1'b0, OFS_STAT, 32'h0);
    `CHK(q[0], 1'b1)
    rchk(5'h14, 32'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_SETPT, 32'h11);
    avs_byteenable <= 4'hf;
    rchk(OFS_SETPT, 32'h78);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_RAMP, c);
      ramp_go();
      `CHK(t >= START_N && t <= START_N + 8, 1'b1)
      ramp_len();
      `CHK(l, RC[c])
    end
    // Writes landing in mid-ramp wait for its end
    bus(1'b1, OFS_MODE, 32'h5);
    bus(1'b1, OFS_RAMP, 32'h1);
    ramp_go();
    `CHK(op_dcm, 1'b1)
    `CHK(op_ccm, 1'b0)
    bus(1'b1, OFS_MODE, 32'h3);
    bus(1'b1, OFS_SETPT, 32'h33);
    bus(1'b1, OFS_RAMP, 32'h3);
    `CHK(target, 8'h78)
    `CHK(target_range, 2'h2)
    ramp_len();
    `CHK(l, RC[1])
    cyc(2);
    `CHK(target, 8'h33)
    `CHK(target_range, 2'h1)
    ramp_go();
    ramp_len();
    `CHK(l, RC[3])
    for (int i = 0; i < 5; i++) begin
      mode_pin <= mp[i];
      load_class <= ld[i];
      bus(1'b1, OFS_MODE, {29'h0, 2'h1, fb[i]});
      cyc(250);
      `CHK({op_ccm, op_dcm, op_pfm}, ex[i])
    end
    // Toggling select pin acts as a sync clock
    on_req <= 8'h0c;
    repeat (12) begin
      mode_pin <= ~mode_pin;
      cyc(20);
    end
    `CHK({op_ccm, op_dcm, op_pfm}, 3'h4)
    mode_pin <= 1'b0;
    cyc(250);
    `CHK({op_ccm, op_dcm, op_pfm}, 3'h1)
    fault_tsd <= 1'b1;
    cyc(4);
    `CHK(en_oe, 1'b1)
    `CHK(stage_on, 1'b0)
    fault_tsd <= 1'b0;
    bus(1'b1, OFS_STACK, 32'h1);
    fault_ovlo <= 1'b1;
    cyc(4);
    `CHK(en_oe, 1'b0)
    `CHK(stage_on, 1'b0)
    fault_ovlo <= 1'b0;
    bus(1'b1, OFS_STACK, 32'h0);
    ramp_go();
    `CHK(stage_on, 1'b1)
    peer_fault <= 1'b1;
    cyc(4);
    `CHK(stage_on, 1'b0)
    `CHK(en_oe, 1'b0)
    peer_fault <= 1'b0;
    ext_en <= 1'b0;
    cyc(4);
    `CHK({stage_on, op_ccm, op_dcm, op_pfm}, 4'h0)
    bus(1'b1, OFS_SETPT, 32'h2a);
    rchk(OFS_SETPT, 32'h2a);
    rchk(OFS_RAMP, 32'h3);
    rchk(OFS_MODE, 32'h2);
    wrap_up();
  end
endmodule
